// ---- wsd_top.v ----
// Added by the designer: register access over APB and the register addresses.
`timescale 1ns/1ps
`include "wsd_defines.vh"

module wsd_top #(
  parameter HAS_COMP_TWO = 1
) (
  input  wire        clk_in,
  input  wire        rst_in,
  input  wire        psel_in,
  input  wire        penable_in,
  input  wire        pwrite_in,
  input  wire [7:0]  paddr_in,
  input  wire [31:0] pwdata_in,
  output wire        pready_out,
  output wire        pslverr_out,
  output wire [31:0] prdata_out,
  input  wire        data_in,
  input  wire        mapped_shutdown_pin_in,
  input  wire        comparator_one_in,
  input  wire        comparator_two_in,
  input  wire        logic_cell_two_in,
  output wire [3:0]  wave_out,
  output wire [3:0]  wave_oe_n_out,
  output wire        irq_out
);

  // ----------------------------------------------------------------
  // register address decode
  // ----------------------------------------------------------------
  // true for every offset that holds a register
  function mapped;
    input [7:0] addr;
    begin
      mapped = (addr == `WSD_OFS_SRC_EN)   || (addr == `WSD_OFS_RISE_DB) ||
               (addr == `WSD_OFS_FALL_DB)  || (addr == `WSD_OFS_SD_CTRL) ||
               (addr == `WSD_OFS_IRQ_STAT) || (addr == `WSD_OFS_IRQ_MASK) ||
               (addr == `WSD_OFS_POLARITY);
    end
  endfunction

  // write strobe of one register, decoded once per register
  function wr_hit;
    input [7:0] addr;
    input [7:0] ofs;
    input       strobe;
    begin
      wr_hit = strobe & (addr == ofs);
    end
  endfunction

  reg  [3:0]  src_en_reg;
  reg  [5:0]  rise_delay_count_reg;
  reg  [5:0]  fall_delay_count_reg;
  reg         sd_status_reg;
  reg         sd_status_next;
  reg         restart_en_reg;
  reg  [1:0]  pair_ac_shutdown_state_reg;
  reg  [1:0]  pair_bd_shutdown_state_reg;
  reg         irq_stat_reg;
  reg         irq_mask_reg;
  reg  [3:0]  polarity_reg;
  reg         sd_hold_reg;
  reg         data_prev_reg;
  reg  [31:0] prdata_reg;
  reg  [3:0]  wave_reg;
  reg  [3:0]  oe_n_reg;
  reg  [31:0] rd_mux;

  wire        setup_ph;
  wire        wr_acc;
  wire        wr_ctrl;
  wire        wr_src;
  wire        wr_rise;
  wire        wr_fall;
  wire        wr_irq;
  wire        wr_mask;
  wire        wr_pol;
  wire        sw_clear;
  wire        sw_set;
  wire [3:0]  src_act;
  wire        any_src;
  wire        data_rise;
  wire        sd_start;
  wire        drive_a;
  wire        drive_b;
  wire        db_a;
  wire        db_b;

  // ----------------------------------------------------------------
  // apb handshake, zero wait states
  // ----------------------------------------------------------------
  // pready tied high, every access ends in its first access cycle
  // prdata loads at the setup edge and stands through the access
  // unmapped offsets answer with pslverr and their writes are dropped
  assign setup_ph    = psel_in & ~penable_in;
  assign wr_acc      = psel_in & penable_in & pwrite_in & mapped(paddr_in);
  assign pready_out  = 1'b1;
  assign pslverr_out = psel_in & penable_in & ~mapped(paddr_in);
  assign prdata_out  = prdata_reg;

  // read data mux, unimplemented bits zero
  // the value is frozen into prdata at the setup edge
  always @* begin
    rd_mux = 32'h0000_0000;
    case (paddr_in)
      `WSD_OFS_SRC_EN:   rd_mux[3:0] = src_en_reg;
      `WSD_OFS_RISE_DB:  rd_mux[5:0] = rise_delay_count_reg;
      `WSD_OFS_FALL_DB:  rd_mux[5:0] = fall_delay_count_reg;
      `WSD_OFS_SD_CTRL:  rd_mux[7:0] = {sd_status_reg, restart_en_reg,
                                        pair_bd_shutdown_state_reg,
                                        pair_ac_shutdown_state_reg, 2'h0};
      `WSD_OFS_IRQ_STAT: rd_mux[0]   = irq_stat_reg;
      `WSD_OFS_IRQ_MASK: rd_mux[0]   = irq_mask_reg;
      `WSD_OFS_POLARITY: rd_mux[3:0] = polarity_reg;
      default:           rd_mux      = 32'h0000_0000;
    endcase
  end

  // read data captured in setup phase
  always @(posedge clk_in) begin
    if (rst_in) begin
      prdata_reg <= 32'h0000_0000;
    end else if (setup_ph && !pwrite_in) begin
      prdata_reg <= rd_mux;
    end
  end

  // ----------------------------------------------------------------
  // configuration registers
  // ----------------------------------------------------------------
  // one strobe per register, all taken in the access cycle
  // an offset that raises pslverr never raises a strobe
  assign wr_src  = wr_hit(paddr_in, `WSD_OFS_SRC_EN, wr_acc);
  assign wr_rise = wr_hit(paddr_in, `WSD_OFS_RISE_DB, wr_acc);
  assign wr_fall = wr_hit(paddr_in, `WSD_OFS_FALL_DB, wr_acc);
  assign wr_irq  = wr_hit(paddr_in, `WSD_OFS_IRQ_STAT, wr_acc);
  assign wr_mask = wr_hit(paddr_in, `WSD_OFS_IRQ_MASK, wr_acc);
  assign wr_pol  = wr_hit(paddr_in, `WSD_OFS_POLARITY, wr_acc);

  // source enables, comparator two bit stays low when absent
  always @(posedge clk_in) begin
    if (rst_in) begin
      src_en_reg <= `WSD_RST_SRC_EN;
    end else if (wr_src) begin
      src_en_reg[`WSD_SRC_PIN_BIT]   <= pwdata_in[`WSD_SRC_PIN_BIT];
      src_en_reg[`WSD_SRC_COMP1_BIT] <= pwdata_in[`WSD_SRC_COMP1_BIT];
      src_en_reg[`WSD_SRC_COMP2_BIT] <= (HAS_COMP_TWO != 0) &
                                        pwdata_in[`WSD_SRC_COMP2_BIT];
      src_en_reg[`WSD_SRC_CELL_BIT]  <= pwdata_in[`WSD_SRC_CELL_BIT];
    end
  end

  // rising dead-band count
  always @(posedge clk_in) begin
    if (rst_in) begin
      rise_delay_count_reg <= `WSD_RST_DB;
    end else if (wr_rise) begin
      rise_delay_count_reg <= pwdata_in[5:0];
    end
  end

  // falling dead-band count
  always @(posedge clk_in) begin
    if (rst_in) begin
      fall_delay_count_reg <= `WSD_RST_DB;
    end else if (wr_fall) begin
      fall_delay_count_reg <= pwdata_in[5:0];
    end
  end

  // shutdown control fields, the status bit is kept below
  always @(posedge clk_in) begin
    if (rst_in) begin
      restart_en_reg             <= 1'b0;
      pair_ac_shutdown_state_reg <= `WSD_RST_SD_STATE;
      pair_bd_shutdown_state_reg <= `WSD_RST_SD_STATE;
    end else if (wr_ctrl) begin
      restart_en_reg             <= pwdata_in[`WSD_SD_RESTART_BIT];
      pair_bd_shutdown_state_reg <= pwdata_in[`WSD_SD_BD_HI:`WSD_SD_BD_LO];
      pair_ac_shutdown_state_reg <= pwdata_in[`WSD_SD_AC_HI:`WSD_SD_AC_LO];
    end
  end

  // interrupt mask
  always @(posedge clk_in) begin
    if (rst_in) begin
      irq_mask_reg <= 1'b0;
    end else if (wr_mask) begin
      irq_mask_reg <= pwdata_in[`WSD_IRQ_SD_BIT];
    end
  end

  // output polarity, one bit per leg
  always @(posedge clk_in) begin
    if (rst_in) begin
      polarity_reg <= `WSD_RST_POLARITY;
    end else if (wr_pol) begin
      polarity_reg <= pwdata_in[3:0];
    end
  end

  // ----------------------------------------------------------------
  // shutdown sources and status
  // ----------------------------------------------------------------
  assign src_act[0] = src_en_reg[`WSD_SRC_PIN_BIT] & mapped_shutdown_pin_in;
  assign src_act[1] = src_en_reg[`WSD_SRC_COMP1_BIT] & comparator_one_in;
  assign src_act[2] = src_en_reg[`WSD_SRC_COMP2_BIT] & comparator_two_in;
  assign src_act[3] = src_en_reg[`WSD_SRC_CELL_BIT] & logic_cell_two_in;
  assign any_src    = |src_act;

  // a software clear only takes once every enabled source is quiet
  assign wr_ctrl  = wr_hit(paddr_in, `WSD_OFS_SD_CTRL, wr_acc);
  assign sw_clear = wr_ctrl & ~pwdata_in[`WSD_SD_STATUS_BIT];
  assign sw_set   = wr_ctrl & pwdata_in[`WSD_SD_STATUS_BIT];

  // a software write of one to the status bit forces shutdown
  // an active source wins over any clear
  always @* begin
    sd_status_next = sd_status_reg;
    if (any_src || sw_set) begin
      sd_status_next = 1'b1;
    end else if (sw_clear) begin
      sd_status_next = 1'b0;
    end else if (restart_en_reg) begin
      sd_status_next = 1'b0;
    end
  end

  assign sd_start  = sd_status_next & ~sd_status_reg;
  assign data_rise = data_in & ~data_prev_reg;

  // shutdown status and data input history
  always @(posedge clk_in) begin
    if (rst_in) begin
      sd_status_reg <= 1'b0;
      data_prev_reg <= 1'b0;
    end else begin
      sd_status_reg <= sd_status_next;
      data_prev_reg <= data_in;
    end
  end

  // output hold, a cleared status alone does not release the legs,
  // only the next rising edge of the data input does
  always @(posedge clk_in) begin
    if (rst_in) begin
      sd_hold_reg <= 1'b0;
    end else if (sd_status_next) begin
      sd_hold_reg <= 1'b1;
    end else if (data_rise) begin
      sd_hold_reg <= 1'b0;
    end
  end

  // interrupt flag, a new event in the clear cycle keeps it set
  always @(posedge clk_in) begin
    if (rst_in) begin
      irq_stat_reg <= 1'b0;
    end else if (sd_start) begin
      irq_stat_reg <= 1'b1;
    end else if (wr_irq && pwdata_in[`WSD_IRQ_SD_BIT]) begin
      irq_stat_reg <= 1'b0;
    end
  end

  // level output, high while the unmasked flag stands
  assign irq_out = irq_stat_reg & irq_mask_reg;

  // ----------------------------------------------------------------
  // dead-band generation
  // ----------------------------------------------------------------
  // a path: data delayed on its rise by the rising count
  // b path: inverted data delayed on its rise by the falling count
  // each count adds n cycles to the two cycle bypass latency
  // a falling drive passes at once, so the legs never overlap
  // both drives forced inactive while held so the inactive code passes dead-band
  assign drive_a = data_in & ~sd_hold_reg;
  assign drive_b = ~data_in & ~sd_hold_reg;

  wsd_deadband u_rise (
    .clk_in   (clk_in),
    .rst_in   (rst_in),
    .sig_in   (drive_a),
    .count_in (rise_delay_count_reg),
    .sig_out  (db_a)
  );

  wsd_deadband u_fall (
    .clk_in   (clk_in),
    .rst_in   (rst_in),
    .sig_in   (drive_b),
    .count_in (fall_delay_count_reg),
    .sig_out  (db_b)
  );

  // ----------------------------------------------------------------
  // output stage, pairs a/c and b/d
  // ----------------------------------------------------------------
  // a and c share the a/c state code, b and d the b/d code
  // tri-state releases the leg and parks its data low
  // registered so the legs change only on clock edges
  genvar gi;
  generate
    for (gi = 0; gi < 4; gi = gi + 1) begin : g_out
      wire [1:0] st = (gi % 2 == 0) ? pair_ac_shutdown_state_reg
                                    : pair_bd_shutdown_state_reg;
      wire       db = (gi % 2 == 0) ? db_a : db_b;
      always @(posedge clk_in) begin
        if (rst_in) begin
          wave_reg[gi] <= 1'b0;
          oe_n_reg[gi] <= 1'b1;
        end else if (sd_hold_reg) begin
          oe_n_reg[gi] <= (st == `WSD_ST_TRI);
          case (st)
            `WSD_ST_HIGH:     wave_reg[gi] <= 1'b1;
            `WSD_ST_LOW:      wave_reg[gi] <= 1'b0;
            `WSD_ST_TRI:      wave_reg[gi] <= 1'b0;
            default:          wave_reg[gi] <= db ^ polarity_reg[gi];
          endcase
        end else begin
          oe_n_reg[gi] <= 1'b0;
          wave_reg[gi] <= db ^ polarity_reg[gi];
        end
      end
    end
  endgenerate

  assign wave_out      = wave_reg;
  assign wave_oe_n_out = oe_n_reg;

endmodule // wsd_top

// ---- wsd_defines.vh ----
`ifndef WSD_DEFINES_VH
`define WSD_DEFINES_VH

// ----------------------------------------------------------------
// register byte offsets
// ----------------------------------------------------------------
`define WSD_OFS_SRC_EN      8'h00
`define WSD_OFS_RISE_DB     8'h04
`define WSD_OFS_FALL_DB     8'h08
`define WSD_OFS_SD_CTRL     8'h0c
`define WSD_OFS_IRQ_STAT    8'h10
`define WSD_OFS_IRQ_MASK    8'h14
`define WSD_OFS_POLARITY    8'h18

// ----------------------------------------------------------------
// field positions
// ----------------------------------------------------------------
`define WSD_SRC_PIN_BIT     0
`define WSD_SRC_COMP1_BIT   1
`define WSD_SRC_COMP2_BIT   2
`define WSD_SRC_CELL_BIT    3
`define WSD_SD_STATUS_BIT   7
`define WSD_SD_RESTART_BIT  6
`define WSD_SD_BD_HI        5
`define WSD_SD_BD_LO        4
`define WSD_SD_AC_HI        3
`define WSD_SD_AC_LO        2
`define WSD_IRQ_SD_BIT      0

// ----------------------------------------------------------------
// reset values
// ----------------------------------------------------------------
`define WSD_RST_SRC_EN      4'h0
`define WSD_RST_DB          6'h00
`define WSD_RST_SD_STATE    2'h0
`define WSD_RST_POLARITY    4'h0

// ----------------------------------------------------------------
// shutdown state codes
// ----------------------------------------------------------------
`define WSD_ST_HIGH         2'h3
`define WSD_ST_LOW          2'h2
`define WSD_ST_TRI          2'h1
`define WSD_ST_INACTIVE     2'h0

`endif

// ---- wsd_deadband.v ----
`timescale 1ns/1ps

// ----------------------------------------------------------------
// rising edge delay of one drive signal
// ----------------------------------------------------------------
module wsd_deadband (
  input  wire       clk_in,
  input  wire       rst_in,
  input  wire       sig_in,
  input  wire [5:0] count_in,
  output wire       sig_out
);

  reg       out_reg;
  reg [5:0] cnt_reg;

  // rise waits count cycles, fall passes at once, zero count bypasses
  always @(posedge clk_in) begin
    if (rst_in) begin
      out_reg <= 1'b0;
      cnt_reg <= 6'h00;
    end else if (count_in == 6'h00) begin
      out_reg <= sig_in;
      cnt_reg <= 6'h00;
    end else if (!sig_in) begin
      out_reg <= 1'b0;
      cnt_reg <= 6'h00;
    end else if (!out_reg) begin
      if (cnt_reg >= count_in) begin
        out_reg <= 1'b1;
      end else begin
        cnt_reg <= cnt_reg + 6'h01;
      end
    end
  end

  assign sig_out = out_reg;

endmodule // wsd_deadband

// ---- wsd_assertions.sv ----
`timescale 1ns/1ps

// ------
// port watcher
// ------
module wsd_checker #(
  parameter HAS_COMP_TWO = 1
) (
  input wire        clk_in,
  input wire        rst_in,
  input wire        psel_in,
  input wire        penable_in,
  input wire        pwrite_in,
  input wire [7:0]  paddr_in,
  input wire [31:0] pwdata_in,
  input wire        pready_out,
  input wire        pslverr_out,
  input wire [31:0] prdata_out,
  input wire        data_in,
  input wire        mapped_shutdown_pin_in,
  input wire        comparator_one_in,
  input wire        comparator_two_in,
  input wire        logic_cell_two_in,
  input wire [3:0]  wave_out,
  input wire [3:0]  wave_oe_n_out,
  input wire        irq_out
);
  reg  [3:0] en_q;
  reg  [5:2] st_q;
  reg        mask_q;
  wire       wr = psel_in && penable_in && pwrite_in;
  wire       trig = |(en_q & {logic_cell_two_in, comparator_two_in,
                              comparator_one_in, mapped_shutdown_pin_in});

  // shadow of enables, state codes and mask
  always @(posedge clk_in) begin
    if (rst_in) begin
      en_q <= 4'h0;
      st_q <= 4'h0;
      mask_q <= 1'b0;
    end else if (wr) begin
      if (paddr_in == 8'h00) en_q <= pwdata_in[3:0] & {1'b1, HAS_COMP_TWO != 0, 2'h3};
      if (paddr_in == 8'h0c) st_q <= pwdata_in[5:2];
      if (paddr_in == 8'h14) mask_q <= pwdata_in[0];
    end
  end

  default clocking @(posedge clk_in); endclocking
  default disable iff (rst_in);

  a_ready_high: assert property (pready_out) else $error("ready dropped");
  a_slverr_map: assert property (psel_in && penable_in |->
    pslverr_out == (paddr_in > 8'h18 || paddr_in[1:0] != 2'h0)) else $error("bad slverr");
  a_high_state: assert property (
    (trig && st_q[3:2] == 2'h3 && !psel_in) ##1 !psel_in |=>
    wave_out[0] && wave_out[2] && !wave_oe_n_out[0] && !wave_oe_n_out[2])
    else $error("a/c not high in shutdown");
  a_low_state: assert property (
    (trig && st_q[5:4] == 2'h2 && !psel_in) ##1 !psel_in |=>
    !wave_out[1] && !wave_out[3] && !wave_oe_n_out[1] && !wave_oe_n_out[3])
    else $error("b/d not low in shutdown");
  a_tri_state: assert property (
    (trig && st_q[3:2] == 2'h1 && !psel_in) ##1 !psel_in |=>
    wave_oe_n_out[0] && wave_oe_n_out[2]) else $error("a/c not released");
  a_enable_read: assert property (
    psel_in && penable_in && !pwrite_in && paddr_in == 8'h00 |->
    prdata_out[31:4] == 28'h0 && (HAS_COMP_TWO != 0 || !prdata_out[2]))
    else $error("enable upper bits set");
  a_irq_masked: assert property (irq_out |-> mask_q) else $error("irq while masked");
  a_reset_quiet: assert property ($fell(rst_in) |->
    wave_oe_n_out == 4'hf && !irq_out && prdata_out == 32'h0) else $error("reset state");
endmodule // wsd_checker

bind wsd_top wsd_checker #(.HAS_COMP_TWO(HAS_COMP_TWO)) wsd_checker_inst (
  .clk_in(clk_in), .rst_in(rst_in), .psel_in(psel_in), .penable_in(penable_in),
  .pwrite_in(pwrite_in), .paddr_in(paddr_in), .pwdata_in(pwdata_in),
  .pready_out(pready_out), .pslverr_out(pslverr_out), .prdata_out(prdata_out),
  .data_in(data_in), .mapped_shutdown_pin_in(mapped_shutdown_pin_in),
  .comparator_one_in(comparator_one_in), .comparator_two_in(comparator_two_in),
  .logic_cell_two_in(logic_cell_two_in), .wave_out(wave_out),
  .wave_oe_n_out(wave_oe_n_out), .irq_out(irq_out));

// ---- wsd_bridge_model.sv ----
`timescale 1ns/1ps

// ------
// bridge driver legs
// ------
module wsd_bridge_model (
  input  wire       clk_in,
  input  wire [3:0] wave_in,
  input  wire [3:0] wave_oe_n_in,
  output wire [3:0] pin_out
);
  reg [3:0] last_reg = 4'h0;

  // released leg floats, shown as inverse of last driven level
  assign pin_out = (wave_in & ~wave_oe_n_in) | (~last_reg & wave_oe_n_in);

  // remember driven levels
  always @(posedge clk_in) begin
    last_reg <= (wave_in & ~wave_oe_n_in) | (last_reg & wave_oe_n_in);
  end
endmodule // wsd_bridge_model

// ---- wsd_tb.sv ----
`timescale 1ns/1ps

module testbench;
  reg         clk_in = 1'b0;
  reg         rst_in = 1'b1;
  reg         psel_in = 1'b0;
  reg         penable_in = 1'b0;
  reg         pwrite_in = 1'b0;
  reg  [7:0]  paddr_in = 8'h00;
  reg  [31:0] pwdata_in = 32'h0;
  reg         data_in = 1'b0;
  reg  [3:0]  src = 4'h0;
  wire        pready_out;
  wire        pslverr_out;
  wire [31:0] prdata_out;
  wire [3:0]  wave_out;
  wire [3:0]  wave_oe_n_out;
  wire [3:0]  pin;
  wire        irq_out;
  reg  [31:0] rd;
  reg         er;
  integer     fails = 0;
  integer     comparisons = 0;
  integer     cyc = 0;
  integer     i;
  integer     n;

  wsd_top wsd_top_inst (.clk_in(clk_in), .rst_in(rst_in), .psel_in(psel_in),
    .penable_in(penable_in), .pwrite_in(pwrite_in), .paddr_in(paddr_in),
    .pwdata_in(pwdata_in), .pready_out(pready_out), .pslverr_out(pslverr_out),
    .prdata_out(prdata_out), .data_in(data_in), .mapped_shutdown_pin_in(src[0]),
    .comparator_one_in(src[1]), .comparator_two_in(src[2]),
    .logic_cell_two_in(src[3]), .wave_out(wave_out),
    .wave_oe_n_out(wave_oe_n_out), .irq_out(irq_out));
  wsd_bridge_model wsd_bridge_model_inst (.clk_in(clk_in), .wave_in(wave_out),
    .wave_oe_n_in(wave_oe_n_out), .pin_out(pin));

  always #2 clk_in = ~clk_in;

  // ------
  // helpers
  // ------
  task chk(input string nm, input [31:0] exp, input [31:0] got);
    comparisons = comparisons + 1;
    if (got !== exp) begin
      fails = fails + 1;
      $display("wrong value %s expected %h seen %h", nm, exp, got);
    end
  endtask

  task apb(input [7:0] a, input w, input [31:0] d);
    @(posedge clk_in);
    psel_in <= 1'b1;
    paddr_in <= a;
    pwrite_in <= w;
    pwdata_in <= d;
    @(posedge clk_in);
    penable_in <= 1'b1;
    @(posedge clk_in);
    while (pready_out !== 1'b1) @(posedge clk_in);
    rd = prdata_out;
    er = pslverr_out;
    psel_in <= 1'b0;
    penable_in <= 1'b0;
  endtask

  task wt(input integer k);
    repeat (k) @(posedge clk_in);
    #1;
  endtask

  // edges from a data change until the watched pin goes high
  task edge_time(input v, input integer idx, input [31:0] exp);
    @(posedge clk_in);
    data_in <= v;
    n = 0;
    do begin
      wt(1);
      n = n + 1;
    end while (pin[idx] !== 1'b1 && n < 100);
    chk("edge delay", exp, n);
    wt(80);
  endtask

  // ------
  // scenarios
  // ------
  task t_regs;
    for (i = 12; i < 28; i = i + 4) begin
      apb(i, 1'b0, 32'h0);
      chk("reset value", 32'h0, rd);
    end
    for (i = 0; i < 12; i = i + 4) begin
      apb(i, 1'b0, 32'h0);
      chk("reset value", 32'h0, rd);
      apb(i, 1'b1, 32'hffffffff);
      apb(i, 1'b0, 32'h0);
      chk("written value", i == 0 ? 32'hf : 32'h3f, rd);
      apb(i, 1'b1, 32'h0);
    end
    apb(8'h1c, 1'b0, 32'h0);
    chk("unmapped err", 32'h1, er);
    chk("unmapped data", 32'h0, rd);
    $display("test regs done");
  endtask

  task t_sources;
    apb(8'h14, 1'b1, 32'h1);
    apb(8'h0c, 1'b1, 32'h2c);
    for (i = 0; i < 4; i = i + 1) begin
      @(posedge clk_in);
      src <= 4'h1 << i;
      wt(4);
      chk("disabled pins", 32'ha, pin);
      chk("disabled irq", 32'h0, irq_out);
      apb(8'h00, 1'b1, 32'h1 << i);
      wt(3);
      chk("shut pins", 32'h5, pin);
      chk("shut irq", 32'h1, irq_out);
      @(posedge clk_in);
      src <= 4'h0;
      apb(8'h0c, 1'b1, 32'h2c);
      apb(8'h10, 1'b1, 32'h1);
      apb(8'h00, 1'b1, 32'h0);
      wt(3);
      chk("held pins", 32'h5, pin);
      chk("cleared irq", 32'h0, irq_out);
      @(posedge clk_in);
      data_in <= 1'b1;
      wt(3);
      @(posedge clk_in);
      data_in <= 1'b0;
      wt(4);
      chk("resumed pins", 32'ha, pin);
    end
    $display("test sources done");
  endtask

  task t_deadband;
    apb(8'h04, 1'b1, 32'h3);
    apb(8'h08, 1'b1, 32'h5);
    edge_time(1'b1, 0, 32'd5);
    edge_time(1'b0, 1, 32'd7);
    apb(8'h04, 1'b1, 32'h0);
    apb(8'h08, 1'b1, 32'h0);
    edge_time(1'b1, 0, 32'd2);
    edge_time(1'b0, 1, 32'd2);
    apb(8'h18, 1'b1, 32'hf);
    wt(2);
    chk("inverted pins", 32'h5, pin);
    apb(8'h18, 1'b1, 32'h0);
    $display("test deadband done");
  endtask

  task t_tri_restart;
    for (i = 0; i < 2; i = i + 1) begin
      apb(8'h18, 1'b1, i == 0 ? 32'h0 : 32'ha);
      apb(8'h0c, 1'b1, i == 0 ? 32'h44 : 32'h04);
      apb(8'h00, 1'b1, 32'h2);
      @(posedge clk_in);
      src <= 4'h2;
      wt(3);
      chk("released legs", 32'h5, wave_oe_n_out);
      chk("inactive legs", i == 0 ? 32'h0 : 32'ha, wave_out & 4'ha);
      @(posedge clk_in);
      src <= 4'h0;
      wt(3);
      apb(8'h0c, 1'b0, 32'h0);
      chk("status after", i, rd[7]);
      apb(8'h0c, 1'b1, 32'h0);
      apb(8'h00, 1'b1, 32'h0);
    end
    $display("test restart done");
  endtask

  task give_verdict;
    $display("comparisons %0d fails %0d", comparisons, fails);
    if (fails == 0 && comparisons > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask

  // hang guard
  always @(posedge clk_in) begin
    cyc = cyc + 1;
    if (cyc == 6000) begin
      fails = fails + 1;
      give_verdict;
    end
  end

  // main sequence
  initial begin
    repeat (6) @(posedge clk_in);
    rst_in <= 1'b0;
    t_regs;
    t_sources;
    t_deadband;
    t_tri_restart;
    give_verdict;
  end
endmodule // testbench
